// file: hw/alarm_mgr_pkg.sv
package alarm_mgr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Alarm word layout: bit n carries mask/latch value 2**n
    localparam int          N_ALARM     = 10;
    localparam int          A_AC_FAIL   = 0;
    localparam int          A_TEMP      = 1;
    localparam int          A_TEMP_SLV  = 2;
    localparam int          A_FAN       = 3;
    localparam int          A_FAN_SLV   = 4;
    localparam int          A_INTERLOCK = 5;
    localparam int          A_OVER_V    = 6;
    localparam int          A_FOLDBACK  = 7;
    localparam int          A_EXT_SHDN  = 8;
    localparam int          A_OVER_I    = 9;
    localparam logic [9:0]  MASKABLE    = 10'h19E;
    localparam logic [9:0]  LATCHABLE   = 10'h087;
    localparam logic [9:0]  OUT_KILL    = 10'h3E7;
    localparam logic [9:0]  AUTO_CLEAR  = 10'h13E;
    // Alarm index by precedence rank, rank 0 highest
    localparam logic [9:0][3:0] PREC_IDX =
        {4'h8, 4'h7, 4'h9, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Synchronised pin vector
    localparam int          SYNC_W      = 14;
    localparam int          S_BTN_OUT   = 9;
    localparam int          S_BTN_AUX   = 10;
    localparam int          S_BTN_ENT   = 11;
    localparam int          S_AUX_INH   = 12;
    localparam int          S_CV_MODE   = 13;
    localparam int          B_OUT       = 0;
    localparam int          B_AUX       = 1;
    localparam int          B_ENT       = 2;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          TICK_MS        = 10;
    localparam int          TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
    localparam int          HOLD_CLEAR_MS  = 3000;
    localparam int          HOLD_SETUP_MS  = 1000;
    localparam int          BLINK_MS       = 250;
    localparam int          TICK_W         = 17;
    localparam int          HOLD_W         = 9;
    localparam int          FB_W           = 13;
    localparam int          BLINK_W        = 5;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0]  REG_CMD     = 8'h00;
    localparam logic [7:0]  REG_MASK    = 8'h04;
    localparam logic [7:0]  REG_LATCH   = 8'h08;
    localparam logic [7:0]  REG_COND    = 8'h0C;
    localparam logic [7:0]  REG_PEND    = 8'h10;
    localparam logic [7:0]  REG_STATE   = 8'h14;
    localparam logic [7:0]  REG_AUTO    = 8'h18;
    localparam logic [7:0]  REG_FOLD    = 8'h1C;
    localparam int          CMD_CLEAR   = 0;
    localparam int          CMD_OUT_ON  = 1;
    localparam int          CMD_OUT_OFF = 2;
    localparam int          CMD_AUX_ON  = 3;
    localparam int          CMD_AUX_OFF = 4;
    localparam int          PEND_FLASH  = 10;
    localparam int          PEND_CODE   = 16;
    localparam int          FOLD_DELAY  = 16;
    localparam logic [1:0]  FB_NONE     = 2'h0;
    localparam logic [1:0]  FB_CV       = 2'h1;
    localparam logic [1:0]  FB_CC       = 2'h2;
    localparam logic [FB_W-1:0] FB_DELAY_RST = 13'h0032;

    typedef enum logic [2:0] {
        MODE_NORMAL  = 3'b001,
        MODE_SET_OUT = 3'b010,
        MODE_SET_AUX = 3'b100
    } panel_mode_t;

    typedef struct packed {
        logic ac_fail;
        logic temp;
        logic temp_slave;
        logic fan;
        logic fan_slave;
        logic interlock_open;
        logic over_voltage_alarm;
        logic over_current_alarm;
        logic ext_shutdown;
        logic btn_output;
        logic btn_aux;
        logic btn_enter;
        logic aux_inhibit;
        logic cv_mode;
    } pins_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_t;

    typedef struct packed {
        logic        out_was_on;
        logic        autostart_out;
        logic        autostart_aux;
    } nv_t;

endpackage

// file: hw/alarm_priority_mask_latch.sv
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module alarm_priority_mask_latch
    import alarm_mgr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire pins_t       pins_in,
    input  wire logic        flash_bad_in,
    input  wire logic        boot_done_in,
    input  wire nv_t         nv_in,
    input  wire ahb_req_t    ahb_in,
    output var  logic        hreadyout_out,
    output var  logic        hresp_out,
    output var  logic [31:0] hrdata_out,
    output var  logic        main_output_out,
    output var  logic        aux_rail_low_out,
    output var  logic        aux_rail_high_out,
    output var  logic        aux_lamp_out,
    output var  logic        alarm_led_out,
    output var  logic [3:0]  alarm_code_out,
    output var  logic        alarm_blink_out,
    output var  logic [1:0]  setup_show_out,
    output var  logic        setup_value_out
);

    localparam int HOLD_CLR_T = HOLD_CLEAR_MS / TICK_MS;
    localparam int HOLD_SET_T = HOLD_SETUP_MS / TICK_MS;
    localparam int BLINK_T    = BLINK_MS / TICK_MS;

    if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << TICK_W)) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    typedef struct packed {
        logic [SYNC_W-1:0]        s1;
        logic [SYNC_W-1:0]        s2;
        logic [SYNC_W-1:0]        s3;
        logic [SYNC_W-1:0]        filt;
        logic [TICK_W-1:0]        tick_cnt;
        logic                     tick;
        logic [2:0][HOLD_W-1:0]   hold_cnt;
        logic [2:0]               held;
        panel_mode_t              mode;
        logic                     boot;
        logic                     boot_win;
        logic                     flash;
        logic [N_ALARM-1:0]       mask;
        logic [N_ALARM-1:0]       latch;
        logic [N_ALARM-1:0]       cond;
        logic [N_ALARM-1:0]       pend;
        logic                     led;
        logic                     out_req;
        logic                     main_on;
        logic                     aux_on;
        logic                     as_out;
        logic                     as_aux;
        logic [1:0]               fb_mode;
        logic [FB_W-1:0]          fb_delay;
        logic [FB_W-1:0]          fb_cnt;
        logic                     fb_trip;
        logic [BLINK_W-1:0]       blink_cnt;
        logic                     blink;
        logic [3:0]               code;
        logic                     dp_wr;
        logic [7:0]               dp_addr;
        logic [31:0]              rdata;
        logic                     ready;
        logic                     resp;
    } state_t;

    state_t q;
    state_t d;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic [SYNC_W-1:0]  raw;
    logic [2:0]         press;
    logic [2:0]         hold_hit;
    logic [N_ALARM-1:0] src;
    logic [N_ALARM-1:0] clr_vec;
    logic [N_ALARM-1:0] auto_clr;
    logic [N_ALARM-1:0] pend_nx;
    logic [3:0]         top_rank;
    logic               any_pend;
    logic               cmd_wr;
    logic               clear_ev;
    logic               out_toggle;
    logic               out_on_ev;
    logic               out_off_ev;
    logic               aux_on_ev;
    logic               aux_off_ev;
    logic               killed;
    logic               in_fb_mode;
    logic               addr_ph;
    logic [31:0]        rd_mux;

    // Packed structs put their first member on top; alarm bits start at 0
    assign raw = {pins_in.cv_mode, pins_in.aux_inhibit, pins_in.btn_enter,
                  pins_in.btn_aux, pins_in.btn_output, pins_in.ext_shutdown,
                  pins_in.over_current_alarm, pins_in.over_voltage_alarm,
                  pins_in.interlock_open, pins_in.fan_slave, pins_in.fan,
                  pins_in.temp_slave, pins_in.temp, pins_in.ac_fail};

    always_comb begin
        d = q;
        press = '0;
        hold_hit = '0;

        // Three-stage sync; level moves once stages two and three agree
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end

        // 10 ms time base shared by every hold and delay counter
        d.tick = 1'b0;
        if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 1'b1;
        end

        // Buttons: short press acts on release, long hold fires once
        for (int b = 0; b < 3; b++) begin
            if (q.filt[S_BTN_OUT + b]) begin
                if (q.tick && !q.held[b]) begin
                    d.hold_cnt[b] = q.hold_cnt[b] + 1'b1;
                end
                if (b == B_ENT) begin
                    hold_hit[b] = !q.held[b] &&
                        q.hold_cnt[b] == HOLD_W'(HOLD_CLR_T);
                end else begin
                    hold_hit[b] = !q.held[b] &&
                        q.hold_cnt[b] == HOLD_W'(HOLD_SET_T);
                end
                if (hold_hit[b]) begin
                    d.held[b] = 1'b1;
                end
            end else begin
                press[b] = q.hold_cnt[b] != '0 && !q.held[b];
                d.hold_cnt[b] = '0;
                d.held[b] = 1'b0;
            end
        end

        // Panel mode machine
        out_toggle = 1'b0;
        aux_on_ev = 1'b0;
        aux_off_ev = 1'b0;
        case (q.mode)
            MODE_NORMAL: begin
                if (hold_hit[B_OUT]) begin
                    d.mode = MODE_SET_OUT;
                end else if (hold_hit[B_AUX]) begin
                    d.mode = MODE_SET_AUX;
                end
                out_toggle = press[B_OUT];
                aux_on_ev = press[B_AUX] && !q.aux_on;
                aux_off_ev = press[B_AUX] && q.aux_on;
            end
            MODE_SET_OUT: begin
                if (press[B_OUT]) begin
                    d.as_out = !q.as_out;
                end
                if (press[B_ENT]) begin
                    d.mode = MODE_NORMAL;
                end
            end
            MODE_SET_AUX: begin
                if (press[B_AUX]) begin
                    d.as_aux = !q.as_aux;
                end
                if (press[B_ENT]) begin
                    d.mode = MODE_NORMAL;
                end
            end
            default: begin
                d.mode = MODE_NORMAL;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Bus slave: zero wait states, read data prepared in address phase
        addr_ph = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
        cmd_wr = q.dp_wr && q.dp_addr == REG_CMD;
        d.dp_wr = addr_ph && ahb_in.hwrite;
        d.dp_addr = ahb_in.haddr[7:0];
        d.ready = 1'b1;
        d.resp = 1'b0;
        if (q.dp_wr) begin
            case (q.dp_addr)
                REG_MASK: begin
                    d.mask = ahb_in.hwdata[N_ALARM-1:0] & MASKABLE;
                end
                REG_LATCH: begin
                    d.latch = ahb_in.hwdata[N_ALARM-1:0] & LATCHABLE;
                end
                REG_AUTO: begin
                    d.as_out = ahb_in.hwdata[0];
                    d.as_aux = ahb_in.hwdata[1];
                end
                REG_FOLD: begin
                    d.fb_mode = ahb_in.hwdata[1:0];
                    d.fb_delay = ahb_in.hwdata[FOLD_DELAY +: FB_W];
                end
                default: begin
                end
            endcase
        end
        clear_ev = hold_hit[B_ENT] ||
            (cmd_wr && ahb_in.hwdata[CMD_CLEAR]);
        out_on_ev = (out_toggle && !q.out_req) ||
            (cmd_wr && ahb_in.hwdata[CMD_OUT_ON]);
        out_off_ev = (out_toggle && q.out_req) ||
            (cmd_wr && ahb_in.hwdata[CMD_OUT_OFF]);
        aux_on_ev = aux_on_ev || (cmd_wr && ahb_in.hwdata[CMD_AUX_ON]);
        aux_off_ev = aux_off_ev || (cmd_wr && ahb_in.hwdata[CMD_AUX_OFF]);

        ////////////////////////////////////////////////////////////////////
        // Foldback timer restarts whenever the selected mode is left
        in_fb_mode = q.main_on &&
            ((q.fb_mode == FB_CV && q.filt[S_CV_MODE]) ||
             (q.fb_mode == FB_CC && !q.filt[S_CV_MODE]));
        d.fb_trip = 1'b0;
        if (!in_fb_mode) begin
            d.fb_cnt = '0;
        end else if (q.fb_cnt >= q.fb_delay) begin
            d.fb_trip = 1'b1;
        end else if (q.tick) begin
            d.fb_cnt = q.fb_cnt + 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // Alarm flags
        src = '0;
        src[N_ALARM-1:0] = {q.filt[7], q.filt[8], q.fb_trip,
            q.filt[6:0]};
        d.cond = src & ~q.mask;
        auto_clr = q.pend & AUTO_CLEAR & ~q.latch & ~q.cond;
        top_rank = 4'hF;
        for (int r = N_ALARM - 1; r >= 0; r--) begin
            if (q.pend[PREC_IDX[r]]) begin
                top_rank = 4'(r);
            end
        end
        any_pend = |q.pend;
        clr_vec = '0;
        if (clear_ev && any_pend) begin
            clr_vec[PREC_IDX[top_rank]] = 1'b1;
        end
        // A still-present cause sets the flag again over the clear
        pend_nx = (q.pend & ~clr_vec & ~auto_clr) | q.cond;
        d.pend = pend_nx;

        // Sticky indicator: set wins; cleared only with nothing pending
        if (|q.cond || q.flash) begin
            d.led = 1'b1;
        end else if ((clear_ev || out_on_ev) && pend_nx == '0) begin
            d.led = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////
        // Main output; out_req keeps the pre-alarm state until a latched alarm is cleared
        killed = |(pend_nx & OUT_KILL) || q.flash;
        if (|((clr_vec | auto_clr) & q.latch)) begin
            d.out_req = 1'b0;
        end else if (out_off_ev) begin
            d.out_req = 1'b0;
        end else if (out_on_ev && !killed && !q.filt[A_EXT_SHDN]) begin
            d.out_req = 1'b1;
        end
        // Never rises while the shutdown pin is active, even when masked
        d.main_on = d.out_req && !killed &&
            (q.main_on || !q.filt[A_EXT_SHDN]);

        // Aux output and lamp share one flop source
        if (q.filt[S_AUX_INH]) begin
            d.aux_on = 1'b0;
        end else if (aux_on_ev) begin
            d.aux_on = 1'b1;
        end else if (aux_off_ev) begin
            d.aux_on = 1'b0;
        end

        // Flash fault is only sampled while booting and clears only on reset
        if (q.boot_win && flash_bad_in) begin
            d.flash = 1'b1;
        end
        if (boot_done_in) begin
            d.boot_win = 1'b0;
        end

        // Power-up restore, taken one edge after reset release
        d.boot = 1'b0;
        if (q.boot) begin
            d.as_out = nv_in.autostart_out;
            d.as_aux = nv_in.autostart_aux;
            d.out_req = nv_in.autostart_out && nv_in.out_was_on;
            d.main_on = 1'b0;
            d.aux_on = nv_in.autostart_aux;
        end

        ////////////////////////////////////////////////////////////////////
        // Display code and blink phase
        // Blank with the clear itself so the code never outlives the LED
        if (q.flash) begin
            d.code = 4'hF;
        end else if (any_pend && |pend_nx) begin
            d.code = top_rank + 4'h1;
        end else begin
            d.code = 4'h0;
        end
        if (q.tick) begin
            if (q.blink_cnt == BLINK_W'(BLINK_T - 1)) begin
                d.blink_cnt = '0;
                d.blink = !q.blink;
            end else begin
                d.blink_cnt = q.blink_cnt + 1'b1;
            end
        end

        rd_mux = '0;
        case (ahb_in.haddr[7:0])
            REG_MASK:  rd_mux[N_ALARM-1:0] = q.mask;
            REG_LATCH: rd_mux[N_ALARM-1:0] = q.latch;
            REG_COND:  rd_mux[N_ALARM-1:0] = q.cond;
            REG_PEND: begin
                rd_mux[N_ALARM-1:0] = q.pend;
                rd_mux[PEND_FLASH] = q.flash;
                rd_mux[PEND_CODE +: 4] = q.code;
            end
            REG_STATE: rd_mux[3:0] = {q.out_req, q.led, q.aux_on, q.main_on};
            REG_AUTO:  rd_mux[1:0] = {q.as_aux, q.as_out};
            REG_FOLD: begin
                rd_mux[1:0] = q.fb_mode;
                rd_mux[FOLD_DELAY +: FB_W] = q.fb_delay;
            end
            default: rd_mux = '0;
        endcase
        if (addr_ph && !ahb_in.hwrite) begin
            d.rdata = rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.mode <= MODE_NORMAL;
            q.boot <= 1'b1;
            q.boot_win <= 1'b1;
            q.fb_mode <= FB_NONE;
            q.fb_delay <= FB_DELAY_RST;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign hreadyout_out     = q.ready;
    assign hresp_out         = q.resp;
    assign hrdata_out        = q.rdata;
    assign main_output_out   = q.main_on;
    assign aux_rail_low_out  = q.aux_on;
    assign aux_rail_high_out = q.aux_on;
    assign aux_lamp_out      = q.aux_on;
    assign alarm_led_out     = q.led;
    assign alarm_code_out    = q.code;
    assign alarm_blink_out   = q.blink;
    assign setup_show_out    = q.mode[2:1];
    assign setup_value_out   = q.mode[2] ? q.as_aux : q.as_out;

endmodule // alarm_priority_mask_latch

`default_nettype wire

// file: verification/alarm_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_checker
    import alarm_mgr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire pins_t      pins_in,
    input wire logic       main_output_out,
    input wire logic       aux_rail_low_out,
    input wire logic       aux_rail_high_out,
    input wire logic       aux_lamp_out,
    input wire logic       alarm_led_out,
    input wire logic [3:0] alarm_code_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////
    // Pin filter plus decision take up to seven edges, so eight is safe
    logic [3:0] shdn_q;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in || !pins_in.ext_shutdown) shdn_q <= 4'h0;
        else if (shdn_q != 4'hF) shdn_q <= shdn_q + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    a_lamp_follows_aux: assert property (
        aux_lamp_out == aux_rail_low_out && aux_rail_high_out == aux_lamp_out)
        else $error("aux lamp and rails disagree");
    a_inhibit_holds_aux: assert property (
        pins_in.aux_inhibit [*8] |-> !aux_rail_low_out)
        else $error("aux on while inhibited");
    a_shdn_refuses_on: assert property (
        $rose(main_output_out) |-> shdn_q < 4'h8)
        else $error("output turned on during shutdown");
    a_ac_forces_off: assert property (
        pins_in.ac_fail [*8] |-> !main_output_out)
        else $error("output on during supply fault");
    a_ov_forces_off: assert property (
        pins_in.over_voltage_alarm [*8] |-> !main_output_out)
        else $error("output on during overvoltage");
    a_code_lights_led: assert property (
        alarm_code_out != 4'h0 |-> alarm_led_out)
        else $error("alarm shown without indicator");
    a_code_in_range: assert property (
        alarm_code_out <= 4'hA || alarm_code_out == 4'hF)
        else $error("alarm code out of range");
    a_ac_shown_top: assert property (
        pins_in.ac_fail [*8] |-> alarm_code_out inside {4'h1, 4'hF})
        else $error("supply fault not shown first");
endmodule // alarm_checker
`default_nettype wire

// file: verification/panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module panel_model #(
    parameter int TICK = 4
) (
    input  wire logic       clk_in,
    output var  logic [2:0] btn_out
);
    initial btn_out = 3'h0;
    // Long idle after release so the next press is seen as a new one
    task automatic press(input int idx, input int ticks);
        @(posedge clk_in);
        btn_out[idx] <= 1'b1;
        repeat (ticks * TICK) @(posedge clk_in);
        btn_out[idx] <= 1'b0;
        repeat (8 * TICK) @(posedge clk_in);
    endtask
endmodule // panel_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import alarm_mgr_pkg::*;
;
    localparam int TK = 4;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        boot_q = 1'b0;
    logic        flash_q = 1'b0;
    pins_t       pins_q = '0;
    pins_t       pins_w;
    nv_t         nv_q = 3'h6;
    ahb_req_t    ahb_q = '0;
    ahb_req_t    ahb_w;
    logic [2:0]  btn;
    logic        rdy, resp, main_on, aux_lo, aux_hi, lamp, led, sval;
    logic [31:0] rdata;
    logic [3:0]  code;
    logic [1:0]  show;
    logic        blink, blink_was;
    int          fails = 0;
    int          compares = 0;
    initial forever #50 clk = ~clk;
    always_comb begin
        pins_w = pins_q;
        pins_w.btn_output = btn[B_OUT];
        pins_w.btn_aux = btn[B_AUX];
        pins_w.btn_enter = btn[B_ENT];
        ahb_w = ahb_q;
        ahb_w.hready = rdy;
    end
    alarm_priority_mask_latch #(.TICK_CYCLES(TK)) alarm_priority_mask_latch_i (
        .sys_clk_in(clk), .rst_b_in(rst_b), .pins_in(pins_w),
        .flash_bad_in(flash_q), .boot_done_in(boot_q), .nv_in(nv_q),
        .ahb_in(ahb_w), .hreadyout_out(rdy), .hresp_out(resp),
        .hrdata_out(rdata), .main_output_out(main_on),
        .aux_rail_low_out(aux_lo), .aux_rail_high_out(aux_hi),
        .aux_lamp_out(lamp), .alarm_led_out(led), .alarm_code_out(code),
        .alarm_blink_out(blink), .setup_show_out(show),
        .setup_value_out(sval));
    panel_model #(.TICK(TK)) panel_model_i (.clk_in(clk), .btn_out(btn));
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic rst(input nv_t nv);
        nv_q <= nv;
        boot_q <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        boot_q <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        ahb_q.hsel <= 1'b1;
        ahb_q.haddr <= {24'h0, a};
        ahb_q.htrans <= 2'h2;
        ahb_q.hwrite <= wr;
        ahb_q.hsize <= 3'h2;
        do @(posedge clk); while (rdy !== 1'b1);
        ahb_q.hsel <= 1'b0;
        ahb_q.htrans <= 2'h0;
        ahb_q.hwdata <= wd;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = rdata;
        chk(32'(resp), 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        // Let the written effect settle before the next look
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask
    task automatic settle;
        repeat (12) @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst(3'h6);
        rd(REG_STATE, 32'h9);
        wr(REG_MASK, 32'h3FF);
        rd(REG_MASK, 32'h19E);
        wr(REG_LATCH, 32'h3FF);
        rd(REG_LATCH, 32'h87);
        rd(8'h40, 32'h0);
        pins_q.temp <= 1'b1;
        settle;
        rd(REG_COND, 32'h0);
        rd(REG_PEND, 32'h0);
        pins_q.temp <= 1'b0;
        pins_q.over_voltage_alarm <= 1'b1;
        settle;
        rd(REG_COND, 32'h40);
        chk(32'(main_on), 32'h0);
        pins_q.over_voltage_alarm <= 1'b0;
        settle;
        wr(REG_CMD, 32'h1);
        rd(REG_STATE, 32'h9);
        wr(REG_MASK, 32'h0);
        wr(REG_LATCH, 32'h0);
        pins_q.fan <= 1'b1;
        settle;
        rd(REG_STATE, 32'hD);
        chk(32'(code), 32'h4);
        pins_q.ac_fail <= 1'b1;
        settle;
        chk(32'(main_on), 32'h0);
        rd(REG_PEND, 32'h10009);
        rd(REG_COND, 32'h9);
        wr(REG_CMD, 32'h1);
        rd(REG_PEND, 32'h10009);
        pins_q.ac_fail <= 1'b0;
        settle;
        wr(REG_CMD, 32'h1);
        rd(REG_PEND, 32'h40008);
        pins_q.fan <= 1'b0;
        settle;
        rd(REG_PEND, 32'h0);
        rd(REG_STATE, 32'hD);
        wr(REG_CMD, 32'h1);
        rd(REG_STATE, 32'h9);
        wr(REG_LATCH, 32'h1);
        pins_q.ac_fail <= 1'b1;
        settle;
        pins_q.ac_fail <= 1'b0;
        panel_model_i.press(B_ENT, 305);
        rd(REG_STATE, 32'h0);
        wr(REG_MASK, 32'h100);
        pins_q.ext_shutdown <= 1'b1;
        settle;
        wr(REG_CMD, 32'h2);
        rd(REG_STATE, 32'h0);
        pins_q.ext_shutdown <= 1'b0;
        settle;
        wr(REG_CMD, 32'h2);
        rd(REG_STATE, 32'h9);
        blink_was = blink;
        repeat (BLINK_MS / TICK_MS * TK) @(posedge clk);
        chk(32'(blink), 32'(!blink_was));
        panel_model_i.press(B_AUX, 2);
        rd(REG_STATE, 32'hB);
        chk(32'(lamp), 32'h1);
        pins_q.aux_inhibit <= 1'b1;
        settle;
        chk(32'(aux_lo), 32'h0);
        panel_model_i.press(B_AUX, 2);
        rd(REG_STATE, 32'h9);
        pins_q.aux_inhibit <= 1'b0;
        panel_model_i.press(B_OUT, 105);
        chk(32'(show), 32'h1);
        chk(32'(sval), 32'h1);
        panel_model_i.press(B_ENT, 2);
        panel_model_i.press(B_AUX, 105);
        chk(32'(show), 32'h2);
        panel_model_i.press(B_AUX, 2);
        chk(32'(sval), 32'h1);
        panel_model_i.press(B_ENT, 2);
        rd(REG_AUTO, 32'h3);
        wr(REG_FOLD, 32'h0001_0002);
        settle;
        rd(REG_PEND, 32'h90080);
        rd(REG_STATE, 32'hC);
        wr(REG_FOLD, 32'h0);
        wr(REG_CMD, 32'h1);
        rd(REG_STATE, 32'h9);
        flash_q <= 1'b1;
        settle;
        rd(REG_PEND, 32'h0);
        rst(3'h6);
        rd(REG_PEND, 32'hF0400);
        rd(REG_STATE, 32'hC);
        flash_q <= 1'b0;
        wr(REG_CMD, 32'h1);
        rd(REG_PEND, 32'hF0400);
        rst(3'h5);
        rd(REG_STATE, 32'h2);
        results;
    end
endmodule // tb_top
bind alarm_priority_mask_latch alarm_checker #(.TICK_CYCLES(TICK_CYCLES))
    alarm_checker_i (.sys_clk_in, .rst_b_in, .pins_in, .main_output_out,
    .aux_rail_low_out, .aux_rail_high_out, .aux_lamp_out, .alarm_led_out,
    .alarm_code_out);
`default_nettype wire
